/* File: shared/irq_pkg.sv */
// Purpose: constants and carrier types of the external interrupt controller
// Assumes: 8-bit registers on a 32-bit APB, one aligned word per register
// Notes:   register indices are word indices; byte address is four times the index
package irq_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int PADDR_W = 24;
    localparam int LINES   = 6;
    localparam int LINE_W  = 3;

    // ****************************************************************
    // register indices and byte addresses
    // ****************************************************************
    localparam logic [PADDR_W-1:0] IDX_SENSE  = 24'h0e_e014;
    localparam logic [PADDR_W-1:0] IDX_ENABLE = 24'h0e_e015;
    localparam logic [PADDR_W-1:0] IDX_PEND   = 24'h0e_e016;
    localparam logic [PADDR_W-1:0] IDX_PRIO_A = 24'h0e_e018;
    localparam logic [PADDR_W-1:0] IDX_PRIO_B = 24'h0e_e019;
    localparam logic [PADDR_W-1:0] IDX_EV_ST  = 24'h0e_e030;
    localparam logic [PADDR_W-1:0] IDX_EV_CLR = 24'h0e_e031;
    localparam logic [PADDR_W-1:0] IDX_EV_EN  = 24'h0e_e032;

    function automatic logic [PADDR_W-1:0] byte_addr(input logic [PADDR_W-1:0] idx);
        byte_addr = {idx[PADDR_W-3:0], 2'b00};
    endfunction

    localparam logic [PADDR_W-1:0] ADDR_SENSE  = byte_addr(IDX_SENSE);
    localparam logic [PADDR_W-1:0] ADDR_ENABLE = byte_addr(IDX_ENABLE);
    localparam logic [PADDR_W-1:0] ADDR_PEND   = byte_addr(IDX_PEND);
    localparam logic [PADDR_W-1:0] ADDR_PRIO_A = byte_addr(IDX_PRIO_A);
    localparam logic [PADDR_W-1:0] ADDR_PRIO_B = byte_addr(IDX_PRIO_B);
    localparam logic [PADDR_W-1:0] ADDR_EV_ST  = byte_addr(IDX_EV_ST);
    localparam logic [PADDR_W-1:0] ADDR_EV_CLR = byte_addr(IDX_EV_CLR);
    localparam logic [PADDR_W-1:0] ADDR_EV_EN  = byte_addr(IDX_EV_EN);

    // ****************************************************************
    // field layout and reset values
    // ****************************************************************
    localparam int PA_LINE0   = 7;
    localparam int PA_LINE1   = 6;
    localparam int PA_LINE23  = 5;
    localparam int PA_LINE45  = 4;
    localparam logic [7:0] PRIO_B_MASK = 8'hee;
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [LINES-1:0] RST_LINES = 6'h00;
    localparam logic [LINES-1:0] SYNC_IDLE = 6'h3f;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic              busy;
        logic              ack;
        logic [LINE_W-1:0] line;
    } exc_t;

    typedef struct packed {
        logic              valid;
        logic              high;
        logic [LINE_W-1:0] line;
    } req_t;

endpackage

/* File: rtl/irq_line_sync.sv */
// Purpose: two-stage synchroniser and falling edge detect for the request pins
// Assumes: pins idle high
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module irq_line_sync #(
    parameter int N = 6
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [N-1:0] pin,
    output logic      [N-1:0] level,
    output logic      [N-1:0] fall
);

    logic [N-1:0] s1_r;
    logic [N-1:0] s2_r;
    logic [N-1:0] s3_r;

    // ****************************************************************
    // synchroniser
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r <= '1;
            s2_r <= '1;
            s3_r <= '1;
        end
        else
        begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign level = s2_r;
    assign fall  = s3_r & ~s2_r;

endmodule

/* File: rtl/irq_prio_arbiter.sv */
// Purpose: picks one request, high level first, then lowest line
// Assumes: combinational, registered by the caller
// Notes:   none
`timescale 1ns/1ps
module irq_prio_arbiter #(
    parameter int N = 6
) (
    input  wire logic [N-1:0] req,
    input  wire logic [N-1:0] high,
    output irq_pkg::req_t     pick
);

    logic [N-1:0] hi_req;

    always_comb
    begin
        hi_req = req & high;
        pick   = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req[i] && !(|hi_req && !high[i]))
            begin
                pick.valid = 1'b1;
                pick.high  = high[i];
                pick.line  = irq_pkg::LINE_W'(i);
            end
        end
    end

endmodule

/* File: rtl/external_irq_priority_ctrl.sv */
// Purpose: six external interrupt lines with sensing, enables, pending flags
//          and two priority registers, reached over APB
// Assumes: single clock pclk, core handshake on the same clock
// Notes:   registers answer with one wait state
//
// Functional notes
// R1: level mode sets flag while input low
// R2: edge mode sets flag on falling edge
// R3: clear needs prior read of one
// R4: level mode clears on high during handling
// R5: edge mode clears when handling runs
// R6: write zero clears, one ignored, readable
// R7: enable bits gate requests, reset zero
// R8: priority bit zero low, one high
// R9: register A bit to source mapping
// R10: register A fully writable, resets zero
// R11: register B bits 7-5, 3-1 writable
// R12: request while flag and enable; high first
`timescale 1ns/1ps
module external_irq_priority_ctrl (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [irq_pkg::PADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [irq_pkg::LINES-1:0]   external_interrupt_input,
    input  wire irq_pkg::exc_t               exc,
    output irq_pkg::req_t                    core_req,
    output logic      [7:0]                  prio_a_out,
    output logic      [7:0]                  prio_b_out,
    output logic                             irq
);

    localparam int L = irq_pkg::LINES;

    // ****************************************************************
    // state
    // ****************************************************************
    logic [L-1:0]  line_sense_select_bit_r;
    logic [L-1:0]  line_enable_bit_r;
    logic [L-1:0]  line_pending_flag_r;
    logic [L-1:0]  clear_armed_r;
    logic [7:0]    priority_a_r;
    logic [7:0]    priority_b_r;
    logic [L-1:0]  ev_status_r;
    logic [L-1:0]  ev_enable_r;
    logic [L-1:0]  pend_prev_r;
    logic [31:0]   prdata_r;
    logic          pready_r;
    logic          pslverr_r;
    irq_pkg::req_t core_req_r;
    logic          irq_r;

    logic [L-1:0]  in_level;
    logic [L-1:0]  in_fall;
    logic [L-1:0]  line_high;
    irq_pkg::req_t pick;
    logic [31:0]   rd_nxt;
    logic          err_nxt;
    logic          done;
    logic          wr_lane;
    logic          wr_sense;
    logic          wr_enable;
    logic          wr_pend;
    logic          rd_pend;
    logic          wr_prio_a;
    logic          wr_prio_b;
    logic          wr_ev_clr;
    logic          wr_ev_en;

    // ****************************************************************
    // pin synchroniser
    // ****************************************************************
    irq_line_sync #(
        .N (L)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (external_interrupt_input),
        .level   (in_level),
        .fall    (in_fall)
    );

    // ****************************************************************
    // apb decode
    // ****************************************************************
    function automatic logic is_addr(input logic [irq_pkg::PADDR_W-1:0] a,
                                     input logic [irq_pkg::PADDR_W-1:0] ref_a);
        is_addr = (a == ref_a);
    endfunction

    assign done      = psel && penable && pready_r;
    assign wr_lane   = done && pwrite && pstrb[0] && !pslverr_r;
    assign wr_sense  = wr_lane && is_addr(paddr, irq_pkg::ADDR_SENSE);
    assign wr_enable = wr_lane && is_addr(paddr, irq_pkg::ADDR_ENABLE);
    assign wr_pend   = wr_lane && is_addr(paddr, irq_pkg::ADDR_PEND);
    assign wr_prio_a = wr_lane && is_addr(paddr, irq_pkg::ADDR_PRIO_A);
    assign wr_prio_b = wr_lane && is_addr(paddr, irq_pkg::ADDR_PRIO_B);
    assign wr_ev_clr = wr_lane && is_addr(paddr, irq_pkg::ADDR_EV_CLR);
    assign wr_ev_en  = wr_lane && is_addr(paddr, irq_pkg::ADDR_EV_EN);
    assign rd_pend   = done && !pwrite && is_addr(paddr, irq_pkg::ADDR_PEND);

    // read mux, upper bits zero
    always_comb
    begin
        rd_nxt  = '0;
        err_nxt = 1'b0;
        unique case (paddr)
            irq_pkg::ADDR_SENSE:  rd_nxt[L-1:0] = line_sense_select_bit_r;
            irq_pkg::ADDR_ENABLE: rd_nxt[L-1:0] = line_enable_bit_r;
            // R6: flags always readable
            irq_pkg::ADDR_PEND:   rd_nxt[L-1:0] = line_pending_flag_r;
            irq_pkg::ADDR_PRIO_A: rd_nxt[7:0]   = priority_a_r;
            irq_pkg::ADDR_PRIO_B: rd_nxt[7:0]   = priority_b_r;
            irq_pkg::ADDR_EV_ST:  rd_nxt[L-1:0] = ev_status_r;
            irq_pkg::ADDR_EV_CLR: rd_nxt        = '0;
            irq_pkg::ADDR_EV_EN:  rd_nxt[L-1:0] = ev_enable_r;
            default:              err_nxt       = 1'b1;
        endcase
    end

    // ****************************************************************
    // apb answer: one wait state
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
        end
        else if (psel && penable && !pready_r)
        begin
            pready_r  <= 1'b1;
            prdata_r  <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr_r <= err_nxt;
        end
        else
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            line_sense_select_bit_r <= irq_pkg::RST_LINES;
        else if (wr_sense)
            line_sense_select_bit_r <= pwdata[L-1:0];
    end

    // R7: enables reset to zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            line_enable_bit_r <= irq_pkg::RST_LINES;
        else if (wr_enable)
            line_enable_bit_r <= pwdata[L-1:0];
    end

    // R10: all eight bits, reset low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            priority_a_r <= irq_pkg::RST_BYTE;
        else if (wr_prio_a)
            priority_a_r <= pwdata[7:0];
    end

    // R11: only bits 7-5 and 3-1 kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            priority_b_r <= irq_pkg::RST_BYTE;
        else if (wr_prio_b)
            priority_b_r <= pwdata[7:0] & irq_pkg::PRIO_B_MASK;
    end

    // ****************************************************************
    // pending flags
    // ****************************************************************
    // R3: arm from data actually returned
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clear_armed_r <= irq_pkg::RST_LINES;
        else if (rd_pend)
            clear_armed_r <= prdata_r[L-1:0];
        else if (wr_pend)
            clear_armed_r <= irq_pkg::RST_LINES;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            line_pending_flag_r <= irq_pkg::RST_LINES;
        else
        begin
            for (int i = 0; i < L; i++)
            begin
                logic set_c;
                logic hw_clr;
                logic sw_clr;
                logic mine;
                mine = (exc.line == irq_pkg::LINE_W'(i));
                // R1: low level sets
                // R2: falling edge sets
                set_c = line_sense_select_bit_r[i] ? in_fall[i] : !in_level[i];
                // R4: level mode, high during handling
                // R5: edge mode, handling carried out
                hw_clr = line_sense_select_bit_r[i] ? (exc.ack && mine)
                                                    : (exc.busy && mine && in_level[i]);
                // R6: zero clears, one ignored
                // R3: only after reading one
                sw_clr = wr_pend && !pwdata[i] && clear_armed_r[i];
                if (set_c)
                    line_pending_flag_r[i] <= 1'b1;
                else if (hw_clr || sw_clr)
                    line_pending_flag_r[i] <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // event status, clear and enable
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pend_prev_r <= irq_pkg::RST_LINES;
        else
            pend_prev_r <= line_pending_flag_r;
    end

    // set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_status_r <= irq_pkg::RST_LINES;
        else
        begin
            for (int i = 0; i < L; i++)
            begin
                if (line_pending_flag_r[i] && !pend_prev_r[i])
                    ev_status_r[i] <= 1'b1;
                else if (wr_ev_clr && pwdata[i])
                    ev_status_r[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_enable_r <= irq_pkg::RST_LINES;
        else if (wr_ev_en)
            ev_enable_r <= pwdata[L-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_r <= 1'b0;
        else
            irq_r <= |(ev_status_r & ev_enable_r);
    end

    // ****************************************************************
    // request to the core
    // ****************************************************************
    // R9: register A bits 7, 6 for lines 0, 1; bit 5 shared by lines 2-3, bit 4 by lines 4-5
    // R8: bit set means high level
    assign line_high[0] = priority_a_r[irq_pkg::PA_LINE0];
    assign line_high[1] = priority_a_r[irq_pkg::PA_LINE1];
    assign line_high[2] = priority_a_r[irq_pkg::PA_LINE23];
    assign line_high[3] = priority_a_r[irq_pkg::PA_LINE23];
    assign line_high[4] = priority_a_r[irq_pkg::PA_LINE45];
    assign line_high[5] = priority_a_r[irq_pkg::PA_LINE45];

    // R12: flag and enable, high first
    // R7: disabled lines never requested
    irq_prio_arbiter #(
        .N (L)
    ) u_arb (
        .req  (line_pending_flag_r & line_enable_bit_r),
        .high (line_high),
        .pick (pick)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            core_req_r <= '0;
        else
            core_req_r <= pick;
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign core_req   = core_req_r;
    assign prio_a_out = priority_a_r;
    assign prio_b_out = priority_b_r;
    assign irq        = irq_r;

endmodule

/* File: tb/irq_ctrl_monitor.sv */
// Purpose: port assertions for the interrupt controller
// Assumes: one clock, async active low reset
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module irq_ctrl_monitor (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [irq_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [3:0]                  pstrb,
    input wire logic [31:0]                 prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire irq_pkg::req_t               core_req,
    input wire logic [7:0]                  prio_a_out,
    input wire logic [7:0]                  prio_b_out,
    input wire logic                        irq
);
    // ****
    // helpers
    // ****
    function automatic logic hi_of(input logic [2:0] ln, input logic [7:0] pa);
        int b;
        b = (ln < 3'd2) ? 7 - int'(ln) : 6 - int'(ln) / 2;
        return pa[b];
    endfunction

    logic mapped;
    assign mapped = paddr inside {irq_pkg::ADDR_SENSE, irq_pkg::ADDR_ENABLE, irq_pkg::ADDR_PEND,
                                  irq_pkg::ADDR_PRIO_A, irq_pkg::ADDR_PRIO_B, irq_pkg::ADDR_EV_ST,
                                  irq_pkg::ADDR_EV_CLR, irq_pkg::ADDR_EV_EN};

    // ****
    // properties
    // ****
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence

    property p_one_wait;
        s_setup |=> !pready ##1 pready;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_err_map;
        psel && penable && !pready |=> pready && (pslverr == !mapped);
    endproperty
    property p_rd_upper;
        pready && !pwrite |-> prdata[31:8] == 24'h00_0000;
    endproperty
    property p_prio_a_wr;
        s_done and (pwrite && pstrb[0] && paddr == irq_pkg::ADDR_PRIO_A) |=> ##1 prio_a_out == $past(pwdata[7:0], 2);
    endproperty
    property p_prio_b_wr;
        s_done and (pwrite && pstrb[0] && paddr == irq_pkg::ADDR_PRIO_B) |=> ##1
            prio_b_out == ($past(pwdata[7:0], 2) & irq_pkg::PRIO_B_MASK);
    endproperty
    property p_prio_b_rsv;
        (prio_b_out & ~irq_pkg::PRIO_B_MASK) == 8'h00;
    endproperty
    property p_prio_a_rd;
        s_done and (!pwrite && paddr == irq_pkg::ADDR_PRIO_A) |-> prdata[7:0] == prio_a_out;
    endproperty
    property p_req_high;
        core_req.valid && $stable(prio_a_out) |-> core_req.high == hi_of(core_req.line, prio_a_out);
    endproperty
    property p_reset_vals;
        disable iff (1'b0) $rose(presetn) |-> prio_a_out == 8'h00 && prio_b_out == 8'h00 && !core_req.valid && !irq;
    endproperty

    a_one_wait: assert property (p_one_wait) else $error("pready not after one wait state");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    a_err_map: assert property (p_err_map) else $error("pslverr does not match address map");
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits not zero");
    a_prio_a_wr: assert property (p_prio_a_wr) else $error("priority A not written");
    a_prio_b_wr: assert property (p_prio_b_wr) else $error("priority B not written");
    a_prio_b_rsv: assert property (p_prio_b_rsv) else $error("priority B unused bit set");
    a_prio_a_rd: assert property (p_prio_a_rd) else $error("priority A read wrong");
    a_req_high: assert property (p_req_high) else $error("request level wrong");
    a_reset_vals: assert property (p_reset_vals) else $error("outputs not clear after reset");
endmodule

/* File: tb/core_exc_model.sv */
// Purpose: core exception handling that serves requests
// Assumes: same clock as the controller
// Notes:   hold sets handling length, take gates acceptance
`timescale 1ns/1ps
module core_exc_model (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          take,
    input  wire logic [3:0]    hold,
    input  wire irq_pkg::req_t core_req,
    output irq_pkg::exc_t      exc
);
    logic [3:0] cnt_r;

    // ****
    // handling
    // ****
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            exc   <= '0;
            cnt_r <= 4'h0;
        end
        else
        begin
            exc.ack <= 1'b0;
            if (cnt_r != 4'h0)
                cnt_r <= cnt_r - 4'h1;
            else if (exc.busy)
            begin
                exc.busy <= 1'b0;
                exc.ack  <= 1'b1;
                cnt_r    <= 4'h3;
            end
            else if (take && core_req.valid)
            begin
                exc.busy <= 1'b1;
                exc.line <= core_req.line;
                cnt_r    <= hold;
            end
        end
    end
endmodule

/* File: tb/external_irq_priority_ctrl_test.sv */
// Purpose: self-checking bench of the interrupt controller
// Assumes: one wait state APB slave
// Notes:   ra order: sense enable pend prioA prioB evst evclr even
`timescale 1ns/1ps
module external_irq_priority_ctrl_test;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, take;
    logic [23:0]   paddr;
    logic [31:0]   pwdata, prdata;
    logic [3:0]    pstrb, hold;
    logic [5:0]    pins;
    logic [7:0]    pa_a, pb_a, d;
    irq_pkg::exc_t exc;
    irq_pkg::req_t core_req;
    int            err_total, cmp_count, k;
    logic [23:0]   ra [8];

    external_irq_priority_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .external_interrupt_input(pins), .exc, .core_req, .prio_a_out(pa_a), .prio_b_out(pb_a),
        .irq);
    core_exc_model core (.pclk, .presetn, .take, .hold, .core_req, .exc);

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ****
    // tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [23:0] a, input logic w, input logic [7:0] dd, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h00_0000, dd};
        @(posedge pclk);
        penable <= 1'b1;
        // sample at the rising edge, release right after it
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [23:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, 8'h00, r, e);
        chk(r, x);
    endtask
    task automatic wr(input logic [23:0] a, input logic [7:0] dd);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, dd, r, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic pulse(input int ln);
        pins[ln] <= 1'b0;
        tick(2);
        pins[ln] <= 1'b1;
        tick(5);
    endtask
    function automatic logic hi(input int i, input logic [7:0] pa);
        return pa[i < 2 ? 7 - i : 6 - i / 2];
    endfunction
    function automatic logic [31:0] exp_req(input logic [5:0] act, input logic [7:0] pa);
        logic [4:0] best;
        best = 5'h00;
        for (int i = 5; i >= 0; i--)
            if (act[i] && (!best[4] || hi(i, pa) >= best[3]))
                best = {1'b1, hi(i, pa), 3'(i)};
        return {27'h000_0000, best};
    endfunction
    task automatic end_of_test;
        $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****
    // tests
    // ****
    initial
    begin
        ra = '{irq_pkg::ADDR_SENSE, irq_pkg::ADDR_ENABLE, irq_pkg::ADDR_PEND, irq_pkg::ADDR_PRIO_A,
               irq_pkg::ADDR_PRIO_B, irq_pkg::ADDR_EV_ST, irq_pkg::ADDR_EV_CLR, irq_pkg::ADDR_EV_EN};
        {psel, penable, pwrite, take} = 4'h0;
        paddr   = 24'h00_0000;
        pwdata  = 32'h0000_0000;
        pstrb   = 4'hf;
        hold    = 4'h0;
        pins    = 6'h3f;
        presetn = 1'b0;
        void'($urandom(32'h5b89_6d0e));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd(ra[i], 32'h0000_0000);
        $display("test reset done");
        repeat (4)
        begin
            d = 8'($urandom);
            wr(ra[3], d);
            rd(ra[3], {24'h00_0000, d});
            wr(ra[4], d);
            rd(ra[4], {24'h00_0000, d & irq_pkg::PRIO_B_MASK});
        end
        pstrb <= 4'he;
        wr(ra[3], 8'hff);
        pstrb <= 4'hf;
        rd(ra[3], {24'h00_0000, d});
        $display("test priority done");
        begin
            logic [31:0] r;
            logic        e;
            apb(24'h3b_8068, 1'b0, 8'h00, r, e);
            chk({31'h0000_0000, e}, 32'h0000_0001);
        end
        $display("test unmapped done");
        wr(ra[3], 8'h10);
        pins <= 6'h2d;
        tick(6);
        rd(ra[2], 32'h0000_0012);
        @(negedge pclk);
        chk({27'h000_0000, core_req}, 32'h0000_0000);
        wr(ra[1], 8'h3f);
        tick(1);
        @(negedge pclk);
        chk({27'h000_0000, core_req}, exp_req(6'h12, 8'h10));
        wr(ra[3], 8'h00);
        tick(1);
        @(negedge pclk);
        chk({27'h000_0000, core_req}, exp_req(6'h12, 8'h00));
        pins <= 6'h3f;
        take <= 1'b1;
        hold <= 4'h2;
        tick(30);
        rd(ra[2], 32'h0000_0000);
        take <= 1'b0;
        $display("test level done");
        wr(ra[1], 8'h00);
        wr(ra[0], 8'h3f);
        repeat (4)
        begin
            k = $urandom_range(5);
            pulse(k);
            rd(ra[2], 32'h1 << k);
            wr(ra[2], 8'hff);
            wr(ra[2], 8'h00);
            rd(ra[2], 32'h1 << k);
            wr(ra[2], 8'h00);
            rd(ra[2], 32'h0000_0000);
        end
        wr(ra[1], 8'h3f);
        take <= 1'b1;
        hold <= 4'h5;
        pulse(k);
        tick(25);
        rd(ra[2], 32'h0000_0000);
        take <= 1'b0;
        $display("test edge done");
        wr(ra[1], 8'h00);
        wr(ra[7], 8'h00);
        wr(ra[6], 8'h3f);
        k = $urandom_range(5);
        pulse(k);
        rd(ra[5], 32'h1 << k);
        @(negedge pclk);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        wr(ra[7], 8'(1 << k));
        tick(2);
        @(negedge pclk);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        wr(ra[6], 8'(1 << k));
        tick(2);
        @(negedge pclk);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rd(ra[5], 32'h0000_0000);
        $display("test event done");
        end_of_test;
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        err_total++;
        end_of_test;
    end
endmodule

bind external_irq_priority_ctrl irq_ctrl_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .core_req, .prio_a_out, .prio_b_out, .irq);
